// file: shared/sut_regs.vh
`ifndef SUT_REGS_VH
`define SUT_REGS_VH

// register offsets on the host bus
`define SUT_ADDR_W 8
`define SUT_OFS_SCRATCH 8'h78
`define SUT_OFS_UNLOCK 8'h7C
`define SUT_OFS_TEST 8'h84

// unlock key
`define SUT_UNLOCK_KEY 16'hAA37

// test register fields
`define SUT_BIT_FORCE_HS 7
`define SUT_BIT_FORCE_FS 4
`define SUT_BIT_RANDOM 3
`define SUT_BIT_K_LEVEL 2
`define SUT_BIT_J_LEVEL 1
`define SUT_BIT_QUIESCENT 0
`define SUT_TEST_RESET 8'h00
`define SUT_TEST_WR_MASK 8'h9F
`define SUT_TEST_BUSRST_KEEP 8'h90

// other reset values
`define SUT_SCRATCH_RESET 16'h0000
`define SUT_RANDOM_SEED 7'h7F

`endif

// file: hdl/sut_bank.v
`timescale 1ns/100ps
`include "sut_regs.vh"

// Overview of operation
// - sixteen-bit scratch register, high byte 15:8, low byte 7:0, no side effects.
// - entering suspend with host unpowered locks all register writes except the unlock key.
// - writing AA37h at 7Ch unlocks register and FIFO writes after resume.
// - eight-bit test register at 84h forces line states for testing.
// - bit 7 forces high-speed only and disables chirp detection.
// - bit 4 forces full-speed only and disables chirp detection.
// - bit 3 toggles the lines in a fixed pseudo-random pattern.
// - bit 2 drives the lines statically to K.
// - bit 1 drives the lines statically to J.
// - bit 0 gives quiescent lines and answers only high-speed IN tokens, NAK.
// - an entered test mode holds until power is cycled.
// - power-on clears test bits; bus reset clears only line-pattern bits.
module sut_bank (
  // clock and power-on reset
  input wire clk_sys,
  input wire reset,
  // host register port
  input wire host_cs,
  input wire host_wr,
  input wire host_rd,
  input wire [`SUT_ADDR_W-1:0] host_addr,
  input wire [15:0] host_wdata,
  output wire [15:0] host_rdata,
  // power and bus state
  input wire host_powered_in_suspend,
  input wire suspend_active,
  input wire usb_bus_reset,
  // write permission to other registers and fifos
  output wire writes_unlocked,
  // speed control
  output wire force_high_speed_only,
  output wire force_full_speed_only,
  output wire chirp_detect_disable,
  // line drive
  output wire line_test_drive,
  output wire line_dp,
  output wire line_dm,
  // token handling in quiescent mode
  input wire hs_in_token,
  output wire quiescent_nak_mode,
  output wire nak_reply
);

  // firmware scratch word
  reg [15:0] scratch_ff;
  reg [15:0] nxt_scratch;

  // test register as software sees it
  reg [7:0] test_ff;
  reg [7:0] nxt_test;

  // modes once applied, kept until power-on
  reg [7:0] held_ff;

  // write lock and suspend edge
  reg lock_ff;
  reg nxt_lock;
  reg susp_ff;

  // registered read data
  reg [15:0] rdata_ff;
  reg [15:0] nxt_rdata;

  // line pattern generator and line levels
  reg [6:0] lfsr_ff;
  reg dp_ff;
  reg dm_ff;
  reg drive_ff;

  // token answer
  reg nak_ff;

  // bus decode helpers
  wire wr_strobe;
  wire wr_ok;
  wire hit_scratch;
  wire hit_unlock;
  wire hit_test;
  wire unlock_hit;

  // suspend entry and pattern feedback
  wire suspend_rise;
  wire lfsr_fb;

  // address decode
  assign wr_strobe = host_cs & host_wr;
  assign hit_scratch = (host_addr == `SUT_OFS_SCRATCH);
  assign hit_unlock = (host_addr == `SUT_OFS_UNLOCK);
  assign hit_test = (host_addr == `SUT_OFS_TEST);
  assign unlock_hit = wr_strobe & hit_unlock & (host_wdata == `SUT_UNLOCK_KEY);
  assign wr_ok = wr_strobe & ~lock_ff;
  assign suspend_rise = suspend_active & ~susp_ff;

  // write lock state
  // strobes float while the host is unpowered, so the lock
  // is taken on suspend entry; lock entry beats an unlock
  // key in the same cycle, since the key may be noise
  always @* begin
    nxt_lock = lock_ff;
    if (unlock_hit) begin
      nxt_lock = 1'b0;
    end
    if (suspend_rise && !host_powered_in_suspend) begin
      nxt_lock = 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      lock_ff <= 1'b0;
      susp_ff <= 1'b0;
    end else begin
      lock_ff <= nxt_lock;
      susp_ff <= suspend_active;
    end
  end

  assign writes_unlocked = ~lock_ff;

  // scratch register
  // plain storage, no hardware reads or side effects
  always @* begin
    nxt_scratch = scratch_ff;
    if (wr_ok && hit_scratch) begin
      nxt_scratch = host_wdata;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      scratch_ff <= `SUT_SCRATCH_RESET;
    end else begin
      scratch_ff <= nxt_scratch;
    end
  end

  // test register next value
  // reserved bits never store, so they read back zero;
  // bus reset is applied after the write so a write in
  // the same cycle cannot keep a line-pattern bit alive
  always @* begin
    nxt_test = test_ff;
    if (wr_ok && hit_test) begin
      nxt_test = host_wdata[7:0] & `SUT_TEST_WR_MASK;
    end
    if (usb_bus_reset) begin
      nxt_test = nxt_test & `SUT_TEST_BUSRST_KEEP;
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      test_ff <= `SUT_TEST_RESET;
    end else begin
      test_ff <= nxt_test;
    end
  end

  // applied modes, held until power-on reset
  // software clearing a bit, or bus reset clearing it,
  // does not release the mode: only power-on does
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_hold
      always @(posedge clk_sys) begin
        if (reset) begin
          held_ff[gi] <= 1'b0;
        end else if (test_ff[gi]) begin
          held_ff[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  assign force_high_speed_only = held_ff[`SUT_BIT_FORCE_HS];
  assign force_full_speed_only = held_ff[`SUT_BIT_FORCE_FS];
  assign chirp_detect_disable = held_ff[`SUT_BIT_FORCE_HS] | held_ff[`SUT_BIT_FORCE_FS];
  assign quiescent_nak_mode = held_ff[`SUT_BIT_QUIESCENT];

  // pattern generator, x^7+x^6+1
  // seeded non-zero so the register never locks up;
  // advances only while the random mode is held
  assign lfsr_fb = lfsr_ff[6] ^ lfsr_ff[5];

  always @(posedge clk_sys) begin
    if (reset) begin
      lfsr_ff <= `SUT_RANDOM_SEED;
    end else if (held_ff[`SUT_BIT_RANDOM]) begin
      lfsr_ff <= {lfsr_ff[5:0], lfsr_fb};
    end
  end

  // line levels, random pattern first
  // several line bits at once are a firmware error;
  // the fixed priority keeps the lines defined anyway
  always @(posedge clk_sys) begin
    if (reset) begin
      dp_ff <= 1'b0;
      dm_ff <= 1'b0;
      drive_ff <= 1'b0;
    end else if (held_ff[`SUT_BIT_RANDOM]) begin
      dp_ff <= lfsr_ff[6];
      dm_ff <= ~lfsr_ff[6];
      drive_ff <= 1'b1;
    end else if (held_ff[`SUT_BIT_K_LEVEL]) begin
      dp_ff <= 1'b0;
      dm_ff <= 1'b1;
      drive_ff <= 1'b1;
    end else if (held_ff[`SUT_BIT_J_LEVEL]) begin
      dp_ff <= 1'b1;
      dm_ff <= 1'b0;
      drive_ff <= 1'b1;
    end else if (held_ff[`SUT_BIT_QUIESCENT]) begin
      dp_ff <= 1'b0;
      dm_ff <= 1'b0;
      drive_ff <= 1'b1;
    end else begin
      dp_ff <= 1'b0;
      dm_ff <= 1'b0;
      drive_ff <= 1'b0;
    end
  end

  assign line_dp = dp_ff;
  assign line_dm = dm_ff;
  assign line_test_drive = drive_ff;

  // NAK to each valid IN token
  // one-cycle pulse, a cycle after the token
  always @(posedge clk_sys) begin
    if (reset) begin
      nak_ff <= 1'b0;
    end else begin
      nak_ff <= hs_in_token & held_ff[`SUT_BIT_QUIESCENT];
    end
  end

  assign nak_reply = nak_ff;

  // read mux
  // data holds between reads; unlock and unmapped
  // offsets give zero rather than stale data
  always @* begin
    nxt_rdata = rdata_ff;
    if (host_cs && host_rd) begin
      nxt_rdata = 16'h0000;
      if (hit_scratch) begin
        nxt_rdata = scratch_ff;
      end
      if (hit_test) begin
        nxt_rdata = {8'h00, test_ff};
      end
    end
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign host_rdata = rdata_ff;

  // notes for users of this bank:
  // - writes_unlocked also gates registers and fifos
  //   outside this bank
  // - the unlock key is accepted even while locked,
  //   every other write is dropped silently
  // - host_powered_in_suspend is sampled at the
  //   suspend entry edge only
  // - test modes last until power-on reset, as the
  //   compliance flow expects
  // - line_test_drive tells the transceiver to take
  //   its levels from line_dp and line_dm

endmodule

// file: testbench/sut_host_model.sv
`timescale 1ns/100ps
module sut_host_model (
  // host bus
  input wire clk_sys,
  output logic host_cs,
  output logic host_wr,
  output logic host_rd,
  output logic [7:0] host_addr,
  output logic [15:0] host_wdata,
  input wire [15:0] host_rdata
);
  initial {host_cs, host_wr, host_rd, host_addr, host_wdata} = 27'h000_0000;
  // one cycle; then strobes drop low and address and data show inverted values
  task cyc(input logic w, input logic [7:0] a, input logic [15:0] v, output logic [15:0] q);
    @(posedge clk_sys) #1;
    {host_cs, host_wr, host_rd, host_addr, host_wdata} = {1'b1, w, !w, a, v};
    @(posedge clk_sys) #1;
    {host_cs, host_wr, host_rd, host_addr, host_wdata} = {3'b000, ~a, ~v};
    q = host_rdata;
  endtask
endmodule

// file: testbench/sut_bank_sva.sv
`timescale 1ns/100ps
module sut_bank_sva (
  // watched ports
  input wire clk_sys,
  input wire reset,
  input wire host_cs,
  input wire host_wr,
  input wire [7:0] host_addr,
  input wire [15:0] host_wdata,
  input wire host_powered_in_suspend,
  input wire suspend_active,
  input wire writes_unlocked,
  input wire force_high_speed_only,
  input wire hs_in_token,
  input wire quiescent_nak_mode,
  input wire nak_reply
);
  // accepted test write, key write
  wire tw = host_cs && host_wr && writes_unlocked && host_addr == 8'h84;
  wire kw = host_cs && host_wr && host_addr == 8'h7C && host_wdata == 16'hAA37;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_lock; $rose(suspend_active) && !host_powered_in_suspend |=> !writes_unlocked; endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_stay; !writes_unlocked && !kw |=> !writes_unlocked; endproperty
  a_stay: assert property (p_stay) else $error("stay");
  property p_unl; kw && !$rose(suspend_active) |=> writes_unlocked; endproperty
  a_unl: assert property (p_unl) else $error("unl");
  property p_pwr; $rose(suspend_active) && host_powered_in_suspend && writes_unlocked |=> writes_unlocked; endproperty
  a_pwr: assert property (p_pwr) else $error("pwr");
  property p_hs; tw && host_wdata[7] |-> ##2 force_high_speed_only; endproperty
  a_hs: assert property (p_hs) else $error("hs");
  property p_hold; force_high_speed_only |=> force_high_speed_only; endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_nak; hs_in_token && quiescent_nak_mode |=> nak_reply; endproperty
  a_nak: assert property (p_nak) else $error("nak");
  property p_nak1; nak_reply |-> $past(hs_in_token); endproperty
  a_nak1: assert property (p_nak1) else $error("nak1");
  c_lock: cover property (!writes_unlocked);
  c_hs: cover property (force_high_speed_only);
  c_nak: cover property (nak_reply);
endmodule
bind sut_bank sut_bank_sva u_sva (.*);

// file: testbench/test_sut_bank.sv
`timescale 1ns/100ps
module test_sut_bank;
  logic clk_sys = 0;
  logic reset = 1;
  logic host_powered_in_suspend = 0;
  logic suspend_active = 0;
  logic usb_bus_reset = 0;
  logic hs_in_token = 0;
  wire host_cs, host_wr, host_rd, writes_unlocked, force_high_speed_only, force_full_speed_only;
  wire chirp_detect_disable, line_test_drive, line_dp, line_dm, quiescent_nak_mode, nak_reply;
  wire [7:0] host_addr;
  wire [15:0] host_wdata, host_rdata;
  int fails = 0, total_checks = 0, seed = 22532, scr;
  logic [15:0] d;
  logic [6:0] lf;
  always #2.5 clk_sys = ~clk_sys;
  sut_bank uut (.*);
  sut_host_model u_host (.*);
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] v);
    u_host.cyc(1'b1, a, v, d);
  endtask
  task rc(input logic [7:0] a, input logic [15:0] e, input string n);
    u_host.cyc(1'b0, a, 16'h0000, d);
    chk(n, e, d);
  endtask
  task tk(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task end_of_test;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // watchdog
  initial begin
    #20000;
    fails++;
    end_of_test();
  end
  // main sequence
  initial begin
    tk(8);
    reset = 0;
    rc(8'h84, 16'h0000, "test");
    rc(8'h7C, 16'h0000, "key");
    repeat (3) begin
      scr = $random(seed);
      wr(8'h78, scr[15:0]);
      rc(8'h78, scr[15:0], "scr");
    end
    wr(8'h84, 16'h0064);
    tk(2);
    chk("k", 16'h0001, {line_dp, line_dm});
    rc(8'h84, 16'h0004, "rsv");
    usb_bus_reset = 1;
    tk(1);
    usb_bus_reset = 0;
    rc(8'h84, 16'h0000, "brst");
    chk("k held", 16'h0001, {line_dp, line_dm});
    wr(8'h84, 16'h0080);
    tk(1);
    chk("hs", 16'h0003, {force_high_speed_only, chirp_detect_disable});
    usb_bus_reset = 1;
    tk(1);
    usb_bus_reset = 0;
    rc(8'h84, 16'h0080, "keep");
    // powered suspend, then unpowered lock
    host_powered_in_suspend = 1;
    suspend_active = 1;
    tk(1);
    suspend_active = 0;
    wr(8'h78, 16'h5A5A);
    host_powered_in_suspend = 0;
    suspend_active = 1;
    tk(2);
    chk("lock", 16'h0000, writes_unlocked);
    suspend_active = 0;
    wr(8'h78, 16'h0F0F);
    wr(8'h7C, 16'hAA36);
    wr(8'h7C, 16'hAA37);
    chk("unlock", 16'h0001, writes_unlocked);
    rc(8'h78, 16'h5A5A, "kept");
    // each line mode with full speed, fresh reset
    for (int i = 0; i < 4; i++) begin
      reset = 1;
      tk(8);
      reset = 0;
      wr(8'h84, 16'h0010 | (16'h0001 << i));
      tk(2);
      chk("fs", 16'h0003, {force_full_speed_only, chirp_detect_disable});
      chk("drv", 16'h0001, line_test_drive);
      if (i == 3) begin
        chk("drive_random_pattern", {15'h0000, !line_dp}, {15'h0000, line_dm});
        lf = 7'h7F;
        for (int k = 0; k < 8; k++) begin
          chk("rnd", {15'h0000, lf[6]}, {15'h0000, line_dp});
          lf = {lf[5:0], lf[6] ^ lf[5]};
          tk(1);
        end
      end
      else chk("line", 16'((3 - i) % 3), {line_dp, line_dm});
      if (i == 0) begin
        hs_in_token = 1;
        tk(1);
        hs_in_token = 0;
        chk("nak", 16'h0001, nak_reply);
      end
    end
    end_of_test();
  end
endmodule
